// ===== src/fcd_dma.sv
`timescale 1ns/10ps
`include "fcd_defines.svh"
module fcd_dma (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    // channel programming
    input  wire logic [`FCD_NUM_CHAN-1:0] chan_load,
    input  wire logic [`FCD_ADDR_W-1:0]   load_addr,
    input  wire logic [`FCD_CNT_W-1:0]    load_count,
    input  wire logic [`FCD_NUM_CHAN-1:0] chan_enable,
    input  wire logic [`FCD_NUM_CHAN-1:0] chan_autoinit,
    input  wire logic [`FCD_NUM_CHAN-1:0] chan_decrement,
    input  fcd_pkg::fcd_svc_t             chan_service [`FCD_NUM_CHAN],
    input  fcd_pkg::fcd_xfer_t            chan_xfer [`FCD_NUM_CHAN],
    input  wire logic                     req_active_low,
    input  wire logic                     grant_active_high,
    input  wire logic                     mem_to_mem_enable,
    output logic      [`FCD_NUM_CHAN-1:0] chan_done,
    // peripherals
    input  wire logic [`FCD_NUM_CHAN-1:0] channel_service_request,
    output logic      [`FCD_NUM_CHAN-1:0] channel_service_grant,
    // processor hold handshake and select
    output logic                          bus_hold_request,
    input  wire logic                     bus_hold_grant,
    input  wire logic                     cs_n,
    // address and data
    output logic      [`FCD_BYTE_W-1:0]   addr_lo_o,
    output logic                          addr_lo_oe,
    input  wire logic [`FCD_BYTE_W-1:0]   db_i,
    output logic      [`FCD_BYTE_W-1:0]   db_o,
    output logic                          db_oe,
    output logic                          addr_strobe,
    output logic                          addr_enable,
    // strobes, active low on the pins
    input  wire logic                     peripheral_read_strobe_n_i,
    output logic                          peripheral_read_strobe_n_o,
    output logic                          peripheral_read_strobe_n_oe,
    output logic                          peripheral_write_strobe_n_o,
    output logic                          peripheral_write_strobe_n_oe,
    output logic                          mem_read_strobe_n_o,
    output logic                          mem_read_strobe_n_oe,
    output logic                          mem_write_strobe_n_o,
    output logic                          mem_write_strobe_n_oe,
    // open-drain end of process, active low
    input  wire logic                     end_of_process_line_n_i,
    output logic                          end_of_process_line_n_o,
    output logic                          end_of_process_line_n_oe
);
    import fcd_pkg::*;

    fcd_main_t s_q;
    fcd_main_t s_d;

    logic [`FCD_NUM_CHAN-1:0] req_act;
    logic [`FCD_NUM_CHAN-1:0] pending;
    logic [`FCD_NUM_CHAN-1:0] step;
    logic [`FCD_NUM_CHAN-1:0] term;
    logic [`FCD_NUM_CHAN-1:0] ch_last;
    logic [`FCD_NUM_CHAN-1:0] ch_done;
    logic [`FCD_ADDR_W-1:0]   ch_addr [`FCD_NUM_CHAN];
    logic [1:0]               xch;
    logic [`FCD_ADDR_W-1:0]   addr;
    logic [`FCD_ADDR_W-1:0]   nxt_addr;
    logic                     m2m_go;
    logic                     ext_now;
    logic                     stop;
    logic                     cont;

    ////////////////////////////////////////////////////////////////////////
    // per-channel address and count
    for (genvar i = 0; i < `FCD_NUM_CHAN; i++) begin : g_chan
        fcd_channel u_chan (
            .clk        (clk),
            .sys_rst    (sys_rst),
            .load       (chan_load[i]),
            .load_addr  (load_addr),
            .load_count (load_count),
            .autoinit   (chan_autoinit[i]),
            .decrement  (chan_decrement[i]),
            .step       (step[i]),
            .terminate  (term[i]),
            .cur_addr   (ch_addr[i]),
            .last       (ch_last[i]),
            .done       (ch_done[i])
        );
    end

    function automatic logic [1:0] pick(input logic [`FCD_NUM_CHAN-1:0] p);
        logic [1:0] r;
        r = 2'h0;
        for (int i = `FCD_NUM_CHAN - 1; i >= 0; i--) begin
            if (p[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // request qualification
    always_comb begin
        req_act = channel_service_request
                ^ {`FCD_NUM_CHAN{req_active_low}};
        pending = req_act & chan_enable & ~ch_done;
        if (mem_to_mem_enable) begin
            pending[`FCD_M2M_DST] = 1'b0;
        end
        m2m_go   = mem_to_mem_enable && pending[`FCD_M2M_SRC];
        xch      = s_q.m2m ? (s_q.m2m_wr ? `FCD_M2M_DST : `FCD_M2M_SRC)
                           : s_q.chan;
        addr     = ch_addr[xch];
        nxt_addr = chan_decrement[xch] ? addr - 1'b1 : addr + 1'b1;
        // own pulse reads back low and must not count as external
        ext_now  = !end_of_process_line_n_i && !s_q.eop_drv;
    end

    ////////////////////////////////////////////////////////////////////////
    // transfer sequencer
    always_comb begin
        s_d         = s_q;
        step        = '0;
        term        = '0;
        stop        = 1'b0;
        cont        = 1'b0;
        s_d.adstb   = 1'b0;
        s_d.eop_drv = 1'b0;
        case (s_q.state)
            FCD_IDLE: begin
                s_d.db_oe = 1'b0;
                if (!cs_n && !bus_hold_grant
                    && !peripheral_read_strobe_n_i) begin
                    s_d.db    = {ch_done, req_act};
                    s_d.db_oe = 1'b1;
                end
                if (|pending) begin
                    s_d.hold  = 1'b1;
                    s_d.db_oe = 1'b0;
                    s_d.state = FCD_S0;
                end
            end
            FCD_S0: begin
                // grant is only looked at from the first cycle that the hold request is out
                if (bus_hold_grant) begin
                    if (m2m_go) begin
                        s_d.m2m    = 1'b1;
                        s_d.m2m_wr = 1'b0;
                        s_d.chan   = `FCD_M2M_SRC;
                        s_d.aen    = 1'b1;
                        s_d.drv    = 1'b1;
                        s_d.state  = FCD_S1;
                    end else if (|pending) begin
                        s_d.chan = pick(pending);
                        s_d.grant[pick(pending)] = 1'b1;
                        s_d.aen  = 1'b1;
                        if (chan_service[pick(pending)] == FCD_CASCADE) begin
                            s_d.state = FCD_CASC;
                        end else begin
                            s_d.drv   = 1'b1;
                            s_d.state = FCD_S1;
                        end
                    end else begin
                        s_d.hold  = 1'b0;
                        s_d.state = FCD_IDLE;
                    end
                end
            end
            FCD_CASC: begin
                // strobes stay released; end of process has no effect here
                if (!req_act[s_q.chan]) begin
                    s_d = '0;
                end
            end
            FCD_S1: begin
                s_d.a_lo    = addr[7:0];
                s_d.db      = addr[15:8];
                s_d.db_oe   = 1'b1;
                s_d.adstb   = 1'b1;
                s_d.hi_last = addr[15:8];
                s_d.ext_eop = s_q.ext_eop | ext_now;
                s_d.state   = FCD_S2;
            end
            FCD_S2: begin
                s_d.a_lo    = addr[7:0];
                s_d.db_oe   = s_q.m2m && s_q.m2m_wr;
                s_d.db      = s_q.temp;
                if (s_q.m2m) begin
                    s_d.memr = !s_q.m2m_wr;
                end else if (chan_xfer[s_q.chan] == FCD_TO_MEM) begin
                    s_d.peripheral_read_strobe  = 1'b1;
                end else if (chan_xfer[s_q.chan] == FCD_FROM_MEM) begin
                    s_d.memr = 1'b1;
                end
                s_d.ext_eop = s_q.ext_eop | ext_now;
                s_d.state   = FCD_S3;
            end
            FCD_S3: begin
                if (s_q.m2m) begin
                    s_d.memw = s_q.m2m_wr;
                end else if (chan_xfer[s_q.chan] == FCD_TO_MEM) begin
                    s_d.memw = 1'b1;
                end else if (chan_xfer[s_q.chan] == FCD_FROM_MEM) begin
                    s_d.iow  = 1'b1;
                end
                s_d.eop_drv = ch_last[xch] && (!s_q.m2m || s_q.m2m_wr);
                s_d.ext_eop = s_q.ext_eop | ext_now;
                s_d.state   = FCD_S4;
            end
            FCD_S4: begin
                s_d.peripheral_read_strobe   = 1'b0;
                s_d.iow   = 1'b0;
                s_d.memr  = 1'b0;
                s_d.memw  = 1'b0;
                s_d.db_oe = 1'b0;
                step[xch] = 1'b1;
                if (s_q.m2m && !s_q.m2m_wr) begin
                    s_d.temp    = db_i;
                    s_d.m2m_wr  = 1'b1;
                    s_d.ext_eop = s_q.ext_eop | ext_now;
                    s_d.state   = FCD_S1;
                end else begin
                    stop      = ch_last[xch] || s_q.ext_eop || ext_now;
                    term[xch] = stop;
                    if (s_q.m2m) begin
                        term[`FCD_M2M_SRC] = stop;
                        cont = !stop;
                    end else begin
                        cont = !stop
                            && (chan_service[s_q.chan] == FCD_BLOCK
                            || (chan_service[s_q.chan] == FCD_DEMAND
                            && req_act[s_q.chan]));
                    end
                    if (cont && s_q.m2m) begin
                        s_d.m2m_wr = 1'b0;
                        s_d.state  = FCD_S1;
                    end else if (cont) begin
                        s_d.state = (nxt_addr[15:8] != s_q.hi_last)
                                  ? FCD_S1 : FCD_S2;
                    end else begin
                        s_d         = '0;
                        s_d.eop_drv = 1'b0;
                    end
                end
            end
            default: begin
                s_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins
    assign chan_done             = ch_done;
    assign channel_service_grant = s_q.grant
                                 ^ {`FCD_NUM_CHAN{~grant_active_high}};
    assign bus_hold_request      = s_q.hold;
    assign addr_lo_o             = s_q.a_lo;
    assign addr_lo_oe            = s_q.drv;
    assign db_o                  = s_q.db;
    assign db_oe                 = s_q.db_oe;
    assign addr_strobe           = s_q.adstb;
    assign addr_enable           = s_q.aen;
    assign peripheral_read_strobe_n_o   = ~s_q.peripheral_read_strobe;
    assign peripheral_read_strobe_n_oe  = s_q.drv;
    assign peripheral_write_strobe_n_o  = ~s_q.iow;
    assign peripheral_write_strobe_n_oe = s_q.drv;
    assign mem_read_strobe_n_o          = ~s_q.memr;
    assign mem_read_strobe_n_oe         = s_q.drv;
    assign mem_write_strobe_n_o         = ~s_q.memw;
    assign mem_write_strobe_n_oe        = s_q.drv;
    assign end_of_process_line_n_o      = 1'b0;
    assign end_of_process_line_n_oe     = s_q.eop_drv;
endmodule

// ===== shared/fcd_defines.svh
// Notes on behaviour
// - Four channels; simultaneous requests resolved by fixed priority, channel 0 first.
// - Per channel: enable, auto-reinitialize, address increment or decrement.
// - Request input and grant output active levels are selectable.
// - Memory-to-memory moves: channel 0 is source, channel 1 destination.
// - End-of-process pulses at terminal count; pulled low outside, it ends transfer.
// - A pending request on an enabled channel raises the bus hold request.
// - On hold grant, the highest-priority requester gets its grant and transfer starts; a memory-to-memory move starts without any grant.
// - Low address byte stands on the low address pins during transfer.
// - High address byte goes on the data bus at start or byte change, and for every read and write of a memory-to-memory move.
// - After the address, read then write strobes carry the word.
// - The peripheral read strobe pulses low when the peripheral must drive data.
// - In cascade service the strobes are released, not driven.
// - When idle the read strobe is an input; it reads the status byte.
// - While hold grant is high, chip select is ignored.
// - A word takes four states, three when a block or demand run keeps the high byte; a memory-to-memory word takes eight.
`ifndef FCD_DEFINES_SVH
`define FCD_DEFINES_SVH

`define FCD_NUM_CHAN      4
`define FCD_ADDR_W        16
`define FCD_CNT_W         16
`define FCD_BYTE_W        8
`define FCD_ADDR_RST      16'h0000
`define FCD_CNT_RST       16'h0000
`define FCD_BYTE_RST      8'h00
`define FCD_STAT_REQ_LSB  0
`define FCD_STAT_DONE_LSB 4
`define FCD_M2M_SRC       2'h0
`define FCD_M2M_DST       2'h1

`endif

// ===== shared/fcd_pkg.sv
package fcd_pkg;
`include "fcd_defines.svh"

    typedef enum logic [2:0] {
        FCD_IDLE, FCD_S0, FCD_S1, FCD_S2, FCD_S3, FCD_S4, FCD_CASC
    } fcd_state_t;

    typedef enum logic [1:0] {
        FCD_SINGLE, FCD_BLOCK, FCD_DEMAND, FCD_CASCADE
    } fcd_svc_t;

    typedef enum logic [1:0] {
        FCD_VERIFY, FCD_TO_MEM, FCD_FROM_MEM
    } fcd_xfer_t;

    typedef struct packed {
        logic [`FCD_ADDR_W-1:0] base_addr;
        logic [`FCD_CNT_W-1:0]  base_cnt;
        logic [`FCD_ADDR_W-1:0] cur_addr;
        logic [`FCD_CNT_W-1:0]  cur_cnt;
        logic                   done;
    } fcd_chan_t;

    typedef struct packed {
        fcd_state_t              state;
        logic [1:0]              chan;
        logic [`FCD_NUM_CHAN-1:0] grant;
        logic                    hold;
        logic                    aen;
        logic                    drv;
        logic                    adstb;
        logic [`FCD_BYTE_W-1:0]  a_lo;
        logic [`FCD_BYTE_W-1:0]  db;
        logic                    db_oe;
        logic                    peripheral_read_strobe;
        logic                    iow;
        logic                    memr;
        logic                    memw;
        logic                    eop_drv;
        logic                    ext_eop;
        logic                    m2m;
        logic                    m2m_wr;
        logic [`FCD_BYTE_W-1:0]  temp;
        logic [`FCD_BYTE_W-1:0]  hi_last;
    } fcd_main_t;

endpackage

// ===== src/fcd_channel.sv
`timescale 1ns/10ps
`include "fcd_defines.svh"
module fcd_channel (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // programming
    input  wire logic                   load,
    input  wire logic [`FCD_ADDR_W-1:0] load_addr,
    input  wire logic [`FCD_CNT_W-1:0]  load_count,
    input  wire logic                   autoinit,
    input  wire logic                   decrement,
    // sequencer
    input  wire logic                   step,
    input  wire logic                   terminate,
    output logic      [`FCD_ADDR_W-1:0] cur_addr,
    output logic                        last,
    output logic                        done
);
    import fcd_pkg::*;

    fcd_chan_t s_q;
    fcd_chan_t s_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        if (load) begin
            s_d.base_addr = load_addr;
            s_d.base_cnt  = load_count;
            s_d.cur_addr  = load_addr;
            s_d.cur_cnt   = load_count;
            s_d.done      = 1'b0;
        end else if (step || terminate) begin
            // a memory move ends its source side without a step
            if (terminate && autoinit) begin
                s_d.cur_addr = s_q.base_addr;
                s_d.cur_cnt  = s_q.base_cnt;
                s_d.done     = 1'b0;
            end else begin
                if (step) begin
                    s_d.cur_addr = decrement ? s_q.cur_addr - 1'b1
                                             : s_q.cur_addr + 1'b1;
                    s_d.cur_cnt  = s_q.cur_cnt - 1'b1;
                end
                if (terminate) begin
                    s_d.done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '{base_addr: `FCD_ADDR_RST, base_cnt: `FCD_CNT_RST,
                     cur_addr: `FCD_ADDR_RST, cur_cnt: `FCD_CNT_RST,
                     done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // a count of zero marks the final word
    assign cur_addr = s_q.cur_addr;
    assign last     = (s_q.cur_cnt == `FCD_CNT_RST);
    assign done     = s_q.done;
endmodule

// ===== testbench/fcd_dma_sva.sv
`timescale 1ns/10ps
`include "fcd_defines.svh"
module fcd_dma_sva (
    // clock and reset
    input wire logic                     clk,
    input wire logic                     sys_rst,
    // programming
    input wire logic [`FCD_NUM_CHAN-1:0] chan_enable,
    input fcd_pkg::fcd_svc_t             chan_service [`FCD_NUM_CHAN],
    input wire logic                     req_active_low,
    input wire logic                     grant_active_high,
    input wire logic                     mem_to_mem_enable,
    input wire logic [`FCD_NUM_CHAN-1:0] chan_done,
    // handshakes
    input wire logic [`FCD_NUM_CHAN-1:0] channel_service_request,
    input wire logic [`FCD_NUM_CHAN-1:0] channel_service_grant,
    input wire logic                     bus_hold_request,
    input wire logic                     bus_hold_grant,
    input wire logic                     cs_n,
    // bus
    input wire logic                     addr_lo_oe,
    input wire logic                     db_oe,
    input wire logic                     addr_strobe,
    input wire logic                     addr_enable,
    input wire logic                     peripheral_read_strobe_n_i,
    input wire logic                     peripheral_read_strobe_n_o,
    input wire logic                     peripheral_read_strobe_n_oe,
    input wire logic                     peripheral_write_strobe_n_o,
    input wire logic                     mem_read_strobe_n_o,
    input wire logic                     mem_read_strobe_n_oe,
    input wire logic                     mem_write_strobe_n_o,
    input wire logic                     end_of_process_line_n_oe
);
    import fcd_pkg::*;
    logic [3:0] gact, pend, casc;
    logic       rd_low, wr_low;
    always_comb begin
        gact = channel_service_grant ^ {4{!grant_active_high}};
        pend = (channel_service_request ^ {4{req_active_low}})
             & chan_enable & ~chan_done;
        for (int i = 0; i < 4; i++) begin
            casc[i] = gact[i] && chan_service[i] == FCD_CASCADE;
        end
        rd_low = (peripheral_read_strobe_n_oe && !peripheral_read_strobe_n_o)
              || (mem_read_strobe_n_oe && !mem_read_strobe_n_o);
        wr_low = !peripheral_write_strobe_n_o || !mem_write_strobe_n_o;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    sequence s_read;
        rd_low && !wr_low;
    endsequence
    sequence s_write;
        rd_low && wr_low ##1 !rd_low && !wr_low;
    endsequence
    a_hold_cause: assert property (
        $rose(bus_hold_request) |-> $past(|pend))
        else $error("hold request without pending channel");
    a_one_grant: assert property ($onehot0(gact))
        else $error("more than one grant");
    a_grant_prio: assert property (
        $rose(|gact) && !mem_to_mem_enable
        |-> ((gact - 4'h1) & $past(pend)) == 4'h0)
        else $error("grant skipped a higher channel");
    a_grant_owns: assert property (
        |gact |-> bus_hold_request && addr_enable)
        else $error("grant without bus ownership");
    a_addr_out: assert property (
        addr_strobe |-> addr_lo_oe && db_oe && addr_enable)
        else $error("address strobe without address");
    a_word_steps: assert property (
        addr_strobe && !mem_to_mem_enable |=> s_read ##1 s_write)
        else $error("word strobe order wrong");
    a_read_pulse: assert property (
        $fell(peripheral_read_strobe_n_o)
        |=> !peripheral_read_strobe_n_o ##1 peripheral_read_strobe_n_o)
        else $error("read strobe pulse shape wrong");
    a_cascade_float: assert property (
        |casc |-> !peripheral_read_strobe_n_oe && !addr_lo_oe && !addr_strobe)
        else $error("cascade drives strobes");
    a_status_sel: assert property (
        db_oe && !addr_enable
        |-> $past(!cs_n && !bus_hold_grant && !peripheral_read_strobe_n_i))
        else $error("status read not selected");
    a_eop_end: assert property (
        end_of_process_line_n_oe
        |=> !end_of_process_line_n_oe && !bus_hold_request)
        else $error("end of process did not end");
    a_reset_idle: assert property (disable iff (1'b0)
        sys_rst |=> !bus_hold_request && !addr_enable && !db_oe)
        else $error("reset left bus busy");
endmodule
bind fcd_dma fcd_dma_sva i_fcd_dma_sva (.*);

// ===== testbench/fcd_host_model.sv
`timescale 1ns/10ps
module fcd_host_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // hold handshake
    input  wire logic       bus_hold_request,
    input  wire logic       slow,
    output logic            bus_hold_grant,
    // data bus seen by the device
    output logic      [7:0] db_i
);
    logic [3:0] wait_q;
    logic       grant_q;
    // grant falls with the request so a stale grant is never seen
    assign bus_hold_grant = grant_q && bus_hold_request;
    always_ff @(posedge clk) begin
        if (sys_rst || !bus_hold_request) begin
            wait_q  <= 4'h0;
            grant_q <= 1'b0;
        end else begin
            wait_q <= wait_q + 4'h1;
            if (wait_q >= (slow ? 4'h6 : 4'h1)) begin
                grant_q <= 1'b1;
            end
        end
        // pattern moves every cycle, never a held last value
        db_i <= sys_rst ? 8'h00 : db_i + 8'h3B;
    end
endmodule

// ===== testbench/tb.sv
`timescale 1ns/10ps
module tb;
    import fcd_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, cs_n = 1'b1, slow = 1'b0;
    logic [3:0] chan_load = 4'h0, chan_enable = 4'h0, chan_autoinit = 4'h0;
    logic [3:0] chan_decrement = 4'h0, channel_service_request = 4'h0;
    logic [15:0] load_addr = 16'h0000, load_count = 16'h0000;
    fcd_svc_t chan_service [4];
    fcd_xfer_t chan_xfer [4];
    logic req_active_low = 1'b0, grant_active_high = 1'b1;
    logic mem_to_mem_enable = 1'b0, rd_n = 1'b1, eop_n = 1'b1, track = 1'b1;
    logic [3:0] chan_done, channel_service_grant;
    logic bus_hold_request, bus_hold_grant, addr_lo_oe, db_oe, addr_strobe;
    logic addr_enable, peripheral_read_strobe_n_o, peripheral_read_strobe_n_oe;
    logic peripheral_write_strobe_n_o, peripheral_write_strobe_n_oe;
    logic mem_read_strobe_n_o, mem_read_strobe_n_oe, mem_write_strobe_n_o;
    logic mem_write_strobe_n_oe, end_of_process_line_n_o;
    logic end_of_process_line_n_oe, wl_q;
    logic [7:0] addr_lo_o, db_i, db_o, hi, rd_q;
    logic [15:0] q [$];
    logic [15:0] a3;
    int n_fail = 0, n_tests = 0, seed = 32'he94f;
    // shared pins: device drives or the pull-up level stands
    wire peripheral_read_strobe_n_i =
        peripheral_read_strobe_n_oe ? peripheral_read_strobe_n_o : rd_n;
    wire end_of_process_line_n_i = !end_of_process_line_n_oe && eop_n;
    wire wl = mem_write_strobe_n_oe
        && !(mem_write_strobe_n_o && peripheral_write_strobe_n_o);

    always #10 clk = ~clk;
    fcd_dma i_fcd_dma (.*);
    fcd_host_model i_fcd_host_model (.clk, .sys_rst, .bus_hold_request,
        .slow, .bus_hold_grant, .db_i);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task summarize;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic ld(input int c, input logic [15:0] a, n,
                      input fcd_svc_t s, input fcd_xfer_t x);
        @(posedge clk);
        chan_load[c] <= 1'b1;
        load_addr <= a;
        load_count <= n;
        chan_service[c] <= s;
        chan_xfer[c] <= x;
        chan_enable[c] <= 1'b1;
        @(posedge clk);
        chan_load <= 4'h0;
    endtask
    task automatic wait_hold;
        for (int k = 0; k < 50 && !addr_enable; k++) @(posedge clk);
    endtask
    task automatic drain;
        int k;
        for (k = 0; k < 600 && (q.size() != 0 || bus_hold_request); k++)
            @(posedge clk);
        chk(16'(k < 600), 16'h1, "bus release");
    endtask
    // word monitor: address seen at each write strobe
    always @(posedge clk) begin
        if (addr_strobe) hi <= db_o;
        if (!mem_read_strobe_n_o) rd_q <= db_i;
        wl_q <= wl;
        if (wl && !wl_q && track) begin
            if (q.size() == 0) chk(16'h1, 16'h0, "extra word");
            else chk({hi, addr_lo_o}, q.pop_front(), "word");
            if (db_oe) chk(db_o, rd_q, "moved byte");
        end
    end
    initial begin
        for (int i = 0; i < 4; i++) begin
            chan_service[i] = FCD_SINGLE;
            chan_xfer[i] = FCD_TO_MEM;
        end
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        // single words with carry into the high byte
        ld(0, 16'h12FF, 16'h0001, FCD_SINGLE, FCD_TO_MEM);
        q = '{16'h12FF, 16'h1300};
        channel_service_request[0] <= 1'b1;
        drain;
        chk(chan_done, 4'h1, "done ch0");
        channel_service_request[0] <= 1'b0;
        // block, decrement with borrow, autoinit, slow grant
        slow <= 1'b1;
        chan_decrement[1] <= 1'b1;
        chan_autoinit[1] <= 1'b1;
        ld(1, 16'h3401, 16'h0002, FCD_BLOCK, FCD_FROM_MEM);
        q = '{16'h3401, 16'h3400, 16'h33FF};
        channel_service_request[1] <= 1'b1;
        wait_hold;
        channel_service_request[1] <= 1'b0;
        drain;
        chk(chan_done, 4'h1, "autoinit keeps ch1 live");
        // both low-priority channels at once, inverted polarity
        slow <= 1'b0;
        req_active_low <= 1'b1;
        grant_active_high <= 1'b0;
        channel_service_request <= 4'hF;
        a3 = {1'b1, 15'($random(seed))};
        ld(2, 16'h5000, 16'h0000, FCD_DEMAND, FCD_TO_MEM);
        ld(3, a3, 16'h0000, FCD_SINGLE, FCD_TO_MEM);
        q = '{16'h5000, a3};
        channel_service_request <= 4'h3;
        drain;
        chk(channel_service_grant, 4'hF, "grant idle level");
        channel_service_request <= 4'hF;
        // status read while idle
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk({db_oe, db_o}, 16'h01D0, "status byte");
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        // forced end of a long block
        req_active_low <= 1'b0;
        grant_active_high <= 1'b1;
        channel_service_request <= 4'h0;
        track <= 1'b0;
        ld(0, 16'h0000, 16'h00FF, FCD_BLOCK, FCD_TO_MEM);
        channel_service_request[0] <= 1'b1;
        wait_hold;
        channel_service_request[0] <= 1'b0;
        repeat (12) @(posedge clk);
        eop_n <= 1'b0;
        @(posedge clk);
        eop_n <= 1'b1;
        drain;
        chk(chan_done, 4'hD, "external stop");
        // cascade keeps grant, drives nothing
        ld(3, 16'h0000, 16'h0000, FCD_CASCADE, FCD_TO_MEM);
        channel_service_request[3] <= 1'b1;
        repeat (20) @(posedge clk);
        chk(channel_service_grant, 4'h8, "cascade grant");
        channel_service_request[3] <= 1'b0;
        drain;
        // memory to memory
        track <= 1'b1;
        chan_autoinit[1] <= 1'b0;
        mem_to_mem_enable <= 1'b1;
        ld(0, 16'h0100, 16'h0000, FCD_BLOCK, FCD_TO_MEM);
        ld(1, 16'h0200, 16'h0000, FCD_BLOCK, FCD_TO_MEM);
        q = '{16'h0200};
        channel_service_request[0] <= 1'b1;
        wait_hold;
        channel_service_request[0] <= 1'b0;
        drain;
        chk(chan_done[1:0], 2'h3, "both ends done");
        summarize;
    end
    initial begin
        #400000;
        n_fail++;
        summarize;
    end
endmodule
